// file: design/cel_regs.vh
/*
  Constants of the configuration loader: memory map, field positions,
  command codes, factory defaults and timing figures.
  Assumes inclusion by the top design file of the loader only, by bare name.
*/
`ifndef CEL_REGS_VH
`define CEL_REGS_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CEL_CLK_MHZ        125
`define CEL_CLK_NS         8
`define CEL_INT_MHZ        1
`define CEL_START_DLY_NS   5000
`define CEL_EE_WRITE_US    11000
`define CEL_EE_CNT_W       14

// ----------------------------------------
// Memory map
// ----------------------------------------
`define CEL_REG_LAST       8'h2E
`define CEL_USR_FIRST      8'h40
`define CEL_USR_LAST       8'h7F
`define CEL_CFG_FIRST      8'h80
`define CEL_CFG_LAST       8'hAE
`define CEL_REG_COUNT      47
`define CEL_USR_BYTES      64
`define CEL_REG_WDLO       6'h2C
`define CEL_REG_WDHI       6'h2D
`define CEL_REG_LOCK       6'h2E
`define CEL_LOCK_BIT       0
`define CEL_WDHI_MSB       1

// ----------------------------------------
// Serial port
// ----------------------------------------
`define CEL_DEV_ID         4'hA
`define CEL_CMD_BLKW       8'hC0
`define CEL_CMD_BLKR       8'hC1
`define CEL_CMD_REBOOT     8'hC4

// ----------------------------------------
// Factory defaults
// ----------------------------------------
`define CEL_FACTORY_BYTE   8'h00
`define CEL_PO_CFG_FIRST   8'h0C
`define CEL_PO_CFG_STEP    3
`define CEL_PO_COUNT       10
`define CEL_PO_STAGE_BIT   0
`define CEL_PO_POL_BIT     1

`endif

// file: design/cel_sync.v
/*
  Two-flop synchroniser for a group of asynchronous pin levels.
  Assumes each bit is an independent level; no bus coherence is given.
*/
`timescale 1ns/1ps
`default_nettype none

module cel_sync #(
  parameter integer WIDTH = 1
) (
  input  wire             clock,
  input  wire             nrst,
  input  wire [WIDTH-1:0] din,
  output reg  [WIDTH-1:0] dataSync_r
);

  reg [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      meta_r     <= {WIDTH{1'b0}};
      dataSync_r <= {WIDTH{1'b0}};
    end else begin
      meta_r     <= din;
      dataSync_r <= meta_r;
    end
  end

endmodule // cel_sync

`default_nettype wire

// file: design/cel_tick.v
/*
  Enable-pulse divider: one-cycle pulse every DIV cycles while enabled.
  Assumes a single clock; the count restarts whenever enable drops.
*/
`timescale 1ns/1ps
`default_nettype none

module cel_tick #(
  parameter integer DIV = 125,
  parameter integer W   = 7
) (
  input  wire clock,
  input  wire nrst,
  input  wire enable,
  output reg  tick_r
);

  localparam integer LAST_I = DIV - 1;
  localparam [W-1:0] LAST   = LAST_I[W-1:0];

  reg [W-1:0] cnt_r;

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_r  <= {W{1'b0}};
      tick_r <= 1'b0;
    end else if (!enable) begin
      cnt_r  <= {W{1'b0}};
      tick_r <= 1'b0;
    end else if (cnt_r == LAST) begin
      cnt_r  <= {W{1'b0}};
      tick_r <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + {{(W-1){1'b0}}, 1'b1};
      tick_r <= 1'b0;
    end
  end

endmodule // cel_tick

`default_nettype wire

// file: design/cel_config_loader.v
/*
  Configuration loader with lock: nonvolatile configuration and user
  storage, volatile configuration registers, power-up / reboot load and
  a slave-only two-wire serial port that reaches all of them.
  Assumes SCL, SDA, supply-good and address straps arrive asynchronously;
  programmable output states come from logic on the same clock.
*/
// Functional notes
// - Lock register bit 0 set means configuration locked, clear unlocked.
// - Configuration storage writes accepted after load, refused while locked.
// - Write-disable low register bits 7..0 gate storage writes on outputs 8..1.
// - Write-disable high register bits 0,1 gate on outputs 9,10; rest unused.
// - Write-disable gating covers user storage writes too.
// - Factory default all zero except polarity and output-stage bits at one.
// - Factory default leaves every programmable output high impedance.
// - Send-byte command C4h reloads storage into registers without power cycle.
// - Reboot reload finishes within the power-up load limit.
// - Storage 80h..AEh loads into registers on supply good or reboot.
// - After supply good, wait 5 us, start 1 MHz tick, then copy.
// - During the copy all serial access is blocked.
// - NACK command byte during reboot, storage write, or illegal address.
// - Storage byte write busy up to 11 ms; access refused meanwhile.
// - User storage is 512 bits at 40h..7Fh, readable and writable.
// - Register writes after load act at once and leave storage alone.
// - Stored configuration becomes active at next power-up or reboot.
// - Slave-only port; master drives SCL and starts every transfer.
// - Transactions framed by START or repeated START and a STOP.
// - Every byte is eight bits followed by an acknowledge bit.
// - SDA change while SCL high is taken as START or STOP.
// - Answer address 1010, two strap bits, don't-care; last bit read.
`timescale 1ns/1ps
`default_nettype none
`include "cel_regs.vh"

module cel_config_loader #(
  parameter integer EE_WRITE_TICKS = `CEL_EE_WRITE_US * `CEL_INT_MHZ
) (
  input  wire                          clock,
  input  wire                          nrst,
  input  wire                          sclPin,
  input  wire                          sdaPin,
  output reg                           sdaOut_r,
  output reg                           sdaOeN_r,
  input  wire                          supplyAboveLockout,
  input  wire [1:0]                    addrStrap,
  input  wire [`CEL_PO_COUNT-1:0]      progOutActive,
  output reg                           loadActive_r,
  output reg                           eeWriteBusy_r,
  output wire [`CEL_REG_COUNT*8-1:0]   cfgRegs
);

  // ----------------------------------------
  // Local constants
  // ----------------------------------------
  localparam integer TICK_DIV  = `CEL_CLK_MHZ / `CEL_INT_MHZ;
  localparam integer START_DIV = (`CEL_START_DLY_NS + `CEL_CLK_NS - 1) / `CEL_CLK_NS;
  localparam integer EE_LAST_I = EE_WRITE_TICKS - 1;
  localparam [`CEL_EE_CNT_W-1:0] EE_LAST = EE_LAST_I[`CEL_EE_CNT_W-1:0];

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_ADDR = 3'h1;
  localparam [2:0] S_CMD  = 3'h2;
  localparam [2:0] S_DATA = 3'h3;
  localparam [2:0] S_READ = 3'h4;

  localparam [1:0] L_IDLE = 2'h0;
  localparam [1:0] L_WAIT = 2'h1;
  localparam [1:0] L_COPY = 2'h2;

  // ----------------------------------------
  // Pin synchronisation and bus conditions
  // ----------------------------------------
  wire [4:0] pinSync;

  cel_sync #(
    .WIDTH (5)
  ) uSync (
    .clock      (clock),
    .nrst       (nrst),
    .din        ({sclPin, sdaPin, supplyAboveLockout, addrStrap}),
    .dataSync_r (pinSync)
  );

  wire       sclS   = pinSync[4];
  wire       sdaS   = pinSync[3];
  wire       supS   = pinSync[2];
  wire [1:0] strapS = pinSync[1:0];

  reg sclPrev_r;
  reg sdaPrev_r;
  reg supPrev_r;

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sclPrev_r <= 1'b0;
      sdaPrev_r <= 1'b0;
      supPrev_r <= 1'b0;
    end else begin
      sclPrev_r <= sclS;
      sdaPrev_r <= sdaS;
      supPrev_r <= supS;
    end
  end

  wire sclRise   = sclS & ~sclPrev_r;
  wire sclFall   = ~sclS & sclPrev_r;
  wire startCond = sclS & sclPrev_r & sdaPrev_r & ~sdaS;
  wire stopCond  = sclS & sclPrev_r & ~sdaPrev_r & sdaS;
  wire supRise   = supS & ~supPrev_r;

  // ----------------------------------------
  // Storage and registers
  // ----------------------------------------
  reg [7:0] cfgReg_r [0:`CEL_REG_COUNT-1];
  reg [7:0] cfgEe    [0:`CEL_REG_COUNT-1];
  reg [7:0] userEe   [0:`CEL_USR_BYTES-1];

  integer i;
  integer j;

  // Nonvolatile content: factory image, no reset
  initial begin
    for (i = 0; i < `CEL_REG_COUNT; i = i + 1) begin
      cfgEe[i] = `CEL_FACTORY_BYTE;
    end
    for (i = 0; i < `CEL_PO_COUNT; i = i + 1) begin
      // Active-high, open-drain: outputs float until configured
      cfgEe[`CEL_PO_CFG_FIRST + i * `CEL_PO_CFG_STEP][`CEL_PO_STAGE_BIT] = 1'b1;
      cfgEe[`CEL_PO_CFG_FIRST + i * `CEL_PO_CFG_STEP][`CEL_PO_POL_BIT]   = 1'b1;
    end
    for (i = 0; i < `CEL_USR_BYTES; i = i + 1) begin
      userEe[i] = `CEL_FACTORY_BYTE;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `CEL_REG_COUNT; g = g + 1) begin : gOut
      assign cfgRegs[g*8+7:g*8] = cfgReg_r[g];
    end
  endgenerate

  wire lockSet = cfgReg_r[`CEL_REG_LOCK][`CEL_LOCK_BIT];

  wire [`CEL_PO_COUNT-1:0] inhibitMask = {cfgReg_r[`CEL_REG_WDHI][`CEL_WDHI_MSB:0],
                                          cfgReg_r[`CEL_REG_WDLO]};
  wire writeInhibit = |(inhibitMask & progOutActive);

  // ----------------------------------------
  // Load sequencer
  // ----------------------------------------
  reg  [1:0] ldState_r;
  reg  [5:0] ldIdx_r;
  reg        loaded_r;
  reg        rebootReq_r;
  wire       startTick;
  wire       intTick;

  // Internal 1 MHz rate only runs while something needs it
  cel_tick #(
    .DIV (START_DIV),
    .W   (10)
  ) uStartDly (
    .clock  (clock),
    .nrst   (nrst),
    .enable (ldState_r == L_WAIT),
    .tick_r (startTick)
  );

  cel_tick #(
    .DIV (TICK_DIV),
    .W   (7)
  ) uIntClk (
    .clock  (clock),
    .nrst   (nrst),
    .enable ((ldState_r == L_COPY) | eeWriteBusy_r),
    .tick_r (intTick)
  );

  wire accessOk = loaded_r & ~loadActive_r;

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ldState_r    <= L_IDLE;
      ldIdx_r      <= 6'h00;
      loaded_r     <= 1'b0;
      loadActive_r <= 1'b0;
    end else if (!supS) begin
      // Below lockout nothing is trusted; wait for the next rise
      ldState_r    <= L_IDLE;
      loaded_r     <= 1'b0;
      loadActive_r <= 1'b0;
    end else begin
      case (ldState_r)
        L_IDLE: begin
          if (supRise | rebootReq_r) begin
            ldState_r    <= L_WAIT;
            loaded_r     <= 1'b0;
            loadActive_r <= 1'b1;
          end
        end
        L_WAIT: begin
          if (startTick) begin
            ldState_r <= L_COPY;
            ldIdx_r   <= 6'h00;
          end
        end
        L_COPY: begin
          // 47 bytes at 1 MHz: well inside the 3 ms load limit
          if (intTick) begin
            if ({2'b00, ldIdx_r} == `CEL_REG_LAST) begin
              ldState_r    <= L_IDLE;
              loaded_r     <= 1'b1;
              loadActive_r <= 1'b0;
            end else begin
              ldIdx_r <= ldIdx_r + 6'h01;
            end
          end
        end
        default: begin
          ldState_r <= L_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Register bank and storage writes
  // ----------------------------------------
  reg       regWr_r;
  reg       eeWr_r;
  reg       wrCfg_r;
  reg [5:0] wrIdx_r;
  reg [7:0] wrData_r;

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (j = 0; j < `CEL_REG_COUNT; j = j + 1) begin
        cfgReg_r[j] <= 8'h00;
      end
    end else if ((ldState_r == L_COPY) && intTick) begin
      cfgReg_r[ldIdx_r] <= cfgEe[ldIdx_r];
    end else if (regWr_r) begin
      cfgReg_r[wrIdx_r] <= wrData_r;
    end
  end

  always @(posedge clock) begin
    if (eeWr_r) begin
      if (wrCfg_r) begin
        cfgEe[wrIdx_r] <= wrData_r;
      end else begin
        userEe[wrIdx_r] <= wrData_r;
      end
    end
  end

  reg [`CEL_EE_CNT_W-1:0] eeCnt_r;

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      eeWriteBusy_r <= 1'b0;
      eeCnt_r       <= {`CEL_EE_CNT_W{1'b0}};
    end else if (eeWr_r) begin
      eeWriteBusy_r <= 1'b1;
      eeCnt_r       <= {`CEL_EE_CNT_W{1'b0}};
    end else if (eeWriteBusy_r && intTick) begin
      if (eeCnt_r == EE_LAST) begin
        eeWriteBusy_r <= 1'b0;
      end else begin
        eeCnt_r <= eeCnt_r + {{(`CEL_EE_CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // ----------------------------------------
  // Address decode helpers
  // ----------------------------------------
  function inUser;
    input [7:0] a;
    begin
      inUser = (a >= `CEL_USR_FIRST) && (a <= `CEL_USR_LAST);
    end
  endfunction

  function inCfg;
    input [7:0] a;
    begin
      inCfg = (a >= `CEL_CFG_FIRST) && (a <= `CEL_CFG_LAST);
    end
  endfunction

  // Pointer sticks at the end of its region
  function [7:0] ptrInc;
    input [7:0] a;
    begin
      if ((a == `CEL_REG_LAST) || (a == `CEL_USR_LAST) || (a == `CEL_CFG_LAST)) begin
        ptrInc = a;
      end else begin
        ptrInc = a + 8'h01;
      end
    end
  endfunction

  reg [7:0] ptr_r;
  reg [7:0] rdByte;

  always @* begin
    if (ptr_r <= `CEL_REG_LAST) begin
      rdByte = cfgReg_r[ptr_r[5:0]];
    end else if (inUser(ptr_r)) begin
      rdByte = userEe[ptr_r[5:0]];
    end else if (inCfg(ptr_r)) begin
      rdByte = cfgEe[ptr_r[5:0]];
    end else begin
      rdByte = 8'h00;
    end
  end

  wire [7:0] rxByte;
  wire       cmdLegal = (rxByte <= `CEL_REG_LAST) | inUser(rxByte) | inCfg(rxByte) |
                        (rxByte == `CEL_CMD_BLKW) | (rxByte == `CEL_CMD_BLKR) |
                        (rxByte == `CEL_CMD_REBOOT);
  wire       rxIsMem  = inUser(rxByte) | inCfg(rxByte);

  // ----------------------------------------
  // Two-wire slave
  // ----------------------------------------
  reg [2:0] state_r;
  reg [3:0] bitCnt_r;
  reg [7:0] shift_r;
  reg       ackPh_r;
  reg       mAck_r;
  reg       blkMode_r;
  reg       cntPh_r;

  assign rxByte = shift_r;

  wire eeBlocked = eeWriteBusy_r | writeInhibit | (inCfg(ptr_r) & lockSet);

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_r     <= S_IDLE;
      bitCnt_r    <= 4'h0;
      shift_r     <= 8'h00;
      ackPh_r     <= 1'b0;
      mAck_r      <= 1'b0;
      blkMode_r   <= 1'b0;
      cntPh_r     <= 1'b0;
      ptr_r       <= 8'h00;
      sdaOut_r    <= 1'b0;
      sdaOeN_r    <= 1'b1;
      rebootReq_r <= 1'b0;
      regWr_r     <= 1'b0;
      eeWr_r      <= 1'b0;
      wrCfg_r     <= 1'b0;
      wrIdx_r     <= 6'h00;
      wrData_r    <= 8'h00;
    end else begin
      rebootReq_r <= 1'b0;
      regWr_r     <= 1'b0;
      eeWr_r      <= 1'b0;
      if (startCond) begin
        state_r  <= S_ADDR;
        bitCnt_r <= 4'h0;
        ackPh_r  <= 1'b0;
        sdaOeN_r <= 1'b1;
      end else if (stopCond) begin
        state_r  <= S_IDLE;
        ackPh_r  <= 1'b0;
        sdaOeN_r <= 1'b1;
      end else if ((state_r != S_IDLE) || ackPh_r) begin
        if (sclRise) begin
          if (ackPh_r) begin
            mAck_r <= ~sdaS;
          end else begin
            if (state_r != S_READ) begin
              shift_r <= {shift_r[6:0], sdaS};
            end
            bitCnt_r <= bitCnt_r + 4'h1;
          end
        end else if (sclFall) begin
          if (ackPh_r) begin
            ackPh_r  <= 1'b0;
            bitCnt_r <= 4'h0;
            sdaOeN_r <= 1'b1;
            if (state_r == S_READ) begin
              if (mAck_r) begin
                shift_r  <= rdByte;
                sdaOeN_r <= rdByte[7];
                ptr_r    <= ptrInc(ptr_r);
              end else begin
                state_r <= S_IDLE;
              end
            end
          end else if (state_r == S_READ) begin
            if (bitCnt_r == 4'h8) begin
              ackPh_r  <= 1'b1;
              sdaOeN_r <= 1'b1;
            end else begin
              shift_r  <= {shift_r[6:0], 1'b0};
              sdaOeN_r <= shift_r[6];
            end
          end else if (bitCnt_r == 4'h8) begin
            ackPh_r <= 1'b1;
            state_r <= S_IDLE;
            case (state_r)
              S_ADDR: begin
                if ((shift_r[7:4] == `CEL_DEV_ID) && (shift_r[3:2] == strapS) && accessOk) begin
                  sdaOeN_r <= 1'b0;
                  mAck_r   <= 1'b1;
                  state_r  <= shift_r[0] ? S_READ : S_CMD;
                end
              end
              S_CMD: begin
                // No ACK: state stays idle until the next START
                if (accessOk && !eeWriteBusy_r && cmdLegal) begin
                  sdaOeN_r <= 1'b0;
                  if (shift_r == `CEL_CMD_REBOOT) begin
                    rebootReq_r <= 1'b1;
                  end else if (shift_r == `CEL_CMD_BLKW) begin
                    blkMode_r <= 1'b1;
                    cntPh_r   <= 1'b1;
                    state_r   <= S_DATA;
                  end else if (shift_r != `CEL_CMD_BLKR) begin
                    ptr_r     <= shift_r;
                    blkMode_r <= 1'b0;
                    // A block write cut before its count leaves no stale count phase
                    cntPh_r   <= 1'b0;
                    state_r   <= S_DATA;
                  end
                end
              end
              S_DATA: begin
                if (cntPh_r) begin
                  cntPh_r  <= 1'b0;
                  sdaOeN_r <= 1'b0;
                  state_r  <= S_DATA;
                end else if (accessOk && (ptr_r <= `CEL_REG_LAST)) begin
                  regWr_r  <= 1'b1;
                  wrIdx_r  <= ptr_r[5:0];
                  wrData_r <= shift_r;
                  sdaOeN_r <= 1'b0;
                  state_r  <= S_DATA;
                  if (blkMode_r) begin
                    ptr_r <= ptrInc(ptr_r);
                  end
                end else if (accessOk && (inUser(ptr_r) | inCfg(ptr_r)) && !eeBlocked) begin
                  eeWr_r   <= 1'b1;
                  wrCfg_r  <= inCfg(ptr_r);
                  wrIdx_r  <= ptr_r[5:0];
                  wrData_r <= shift_r;
                  sdaOeN_r <= 1'b0;
                  state_r  <= S_DATA;
                  if (blkMode_r) begin
                    ptr_r <= ptrInc(ptr_r);
                  end
                end
              end
              default: begin
                state_r <= S_IDLE;
              end
            endcase
          end
        end
      end
    end
  end

endmodule // cel_config_loader

`default_nettype wire

// file: design/cel_dummy_placeholder_unused.v
`timescale 1ns/1ps

// file: bench/cel_config_loader_asserts.sv
/* Port checker of the configuration loader.
   Assumes a bind onto cel_config_loader in the bench top. */
`timescale 1ns/1ps
`default_nettype none
module cel_config_loader_asserts #(
  parameter integer EE_WRITE_TICKS = 11000
) (
  input wire logic         clock,
  input wire logic         nrst,
  input wire logic         sclPin,
  input wire logic         sdaPin,
  input wire logic         sdaOut_r,
  input wire logic         sdaOeN_r,
  input wire logic         supplyAboveLockout,
  input wire logic [1:0]   addrStrap,
  input wire logic [9:0]   progOutActive,
  input wire logic         loadActive_r,
  input wire logic         eeWriteBusy_r,
  input wire logic [375:0] cfgRegs
);
  // Busy always starts a fresh 1 us tick; allow one tick of slack either way
  localparam int BMIN = EE_WRITE_TICKS * 125 - 125;
  localparam int BMAX = EE_WRITE_TICKS * 125 + 125;
  int busyCnt;
  int loadCnt;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      busyCnt <= 0;
      loadCnt <= 0;
    end else begin
      busyCnt <= eeWriteBusy_r ? busyCnt + 1 : 0;
      loadCnt <= loadActive_r ? loadCnt + 1 : 0;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  chk_sda_open: assert property (sdaOut_r == 1'b0) else $error("sda driven high");
  chk_ack_scl_low: assert property ($fell(sdaOeN_r) |-> !sclPin) else $error("drive while scl high");
  chk_rel_scl_low: assert property ($rose(sdaOeN_r) |-> !sclPin || !supplyAboveLockout)
    else $error("release while scl high");
  chk_quiet_load: assert property ($fell(sdaOeN_r) |-> !loadActive_r) else $error("ack in load");
  chk_busy_load: assert property ($rose(eeWriteBusy_r) |-> !loadActive_r) else $error("write in load");
  chk_busy_len: assert property ($fell(eeWriteBusy_r) |-> busyCnt >= BMIN && busyCnt <= BMAX)
    else $error("write time wrong");
  chk_load_max: assert property (loadCnt <= 7000) else $error("load too long");
  chk_load_all: assert property ($fell(loadActive_r) && supplyAboveLockout |-> loadCnt >= 5875)
    else $error("load too short");
  chk_load_start: assert property ($rose(supplyAboveLockout) |-> ##[1:700] loadActive_r)
    else $error("load not started");
  chk_cfg_cause: assert property (!$stable(cfgRegs) |->
    loadActive_r || $past(loadActive_r) || !sdaOeN_r || !supplyAboveLockout)
    else $error("registers changed idle");
  cover property ($fell(loadActive_r));
  cover property ($fell(eeWriteBusy_r));
  cover property ($fell(sdaOeN_r) && eeWriteBusy_r);
endmodule // cel_config_loader_asserts
`default_nettype wire

// file: bench/cel_i2c_master.sv
/* Two-wire bus master model with byte tasks.
   Assumes a pulled-up SDA wire resolved by the bench. */
`timescale 1ns/1ps
`default_nettype none
module cel_i2c_master (
  output var logic scl,
  output var logic sdaLow,
  input wire logic sdaWire
);
  realtime q = 31.25;
  realtime slowNs = 0.0;
  // SCL idles high and stands still between frames
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  // SDA only changes in the low phase, one q after SCL falls
  task automatic bitx(input logic b, output logic s);
    sdaLow = !b;
    #(q + slowNs);
    scl = 1'b1;
    #(2 * q);
    s = sdaWire;
    scl = 1'b0;
    #q;
  endtask
  task automatic start;
    sdaLow = 1'b0;
    #q;
    scl = 1'b1;
    #(2 * q);
    sdaLow = 1'b1;
    #(2 * q);
    scl = 1'b0;
    #q;
  endtask
  task automatic stop;
    sdaLow = 1'b1;
    #q;
    scl = 1'b1;
    #(2 * q);
    sdaLow = 1'b0;
    #(2 * q);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(d[i], s);
    bitx(1'b1, s);
    ack = !s;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(last, s);
  endtask
endmodule // cel_i2c_master
`default_nettype wire

// file: bench/cel_config_loader_tb.sv
/* Self-checking bench of the configuration loader.
   Assumes the master model and checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin num_errors++; \
  $display("unexpected at %0t: got %h exp %h", $time, a, e); end end
module cel_config_loader_tb;
  localparam logic [7:0] DEV = 8'hA8;
  logic clock, nrst, supply, sdaWire, scl, sdaLow, sdaOut, sdaOeN, loadActive, busy;
  logic [1:0]   addrStrap;
  logic [9:0]   progOut;
  logic [375:0] cfgRegs;
  int num_errors, n_compared;
  logic [7:0] wdl[4] = '{8'h80, 8'h00, 8'h00, 8'h7F};
  logic [7:0] wdh[4] = '{8'h00, 8'h01, 8'h02, 8'h01};
  logic [9:0] wdo[4] = '{10'h080, 10'h100, 10'h200, 10'h280};
  logic [3:0] blk = 4'b0111;
  assign sdaWire = !(sdaLow || (!sdaOeN && !sdaOut));
  cel_i2c_master m (.scl(scl), .sdaLow(sdaLow), .sdaWire(sdaWire));
  cel_config_loader #(.EE_WRITE_TICKS(20)) dut (.clock(clock), .nrst(nrst), .sclPin(scl),
    .sdaPin(sdaWire), .sdaOut_r(sdaOut), .sdaOeN_r(sdaOeN), .supplyAboveLockout(supply),
    .addrStrap(addrStrap), .progOutActive(progOut), .loadActive_r(loadActive),
    .eeWriteBusy_r(busy), .cfgRegs(cfgRegs));
  initial begin
    clock = 1'b0;
    forever #4 clock = !clock;
  end
  function automatic logic [7:0] cfg(int n);
    return cfgRegs[8*n+:8];
  endfunction
  function automatic logic [7:0] fac(int n);
    return (n >= 12 && n <= 39 && (n - 12) % 3 == 0) ? 8'h03 : 8'h00;
  endfunction
  task give_verdict;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic waitFor(input int sel, input logic v, input int lim);
    int i;
    for (i = 0; i < lim && (sel ? busy : loadActive) !== v; i++) @(posedge clock);
    if (i == lim) begin
      num_errors++;
      $display("unexpected at %0t: wait ran out", $time);
      give_verdict();
    end
  endtask
  // Unsent bytes report as refused
  task automatic wr(input logic [7:0] a, c, d, input int n, input logic [2:0] ex);
    logic [2:0] k;
    k = 3'b000;
    m.start();
    m.wbyte(a, k[2]);
    if (n > 1) m.wbyte(c, k[1]);
    if (n > 2) m.wbyte(d, k[0]);
    m.stop();
    `CHK(k, ex)
  endtask
  task automatic rd(input logic [7:0] p, e);
    logic [2:0] k;
    logic [7:0] d;
    m.start();
    m.wbyte(DEV, k[2]);
    m.wbyte(p, k[1]);
    m.start();
    m.wbyte(DEV | 8'h01, k[0]);
    m.rbyte(1'b1, d);
    m.stop();
    `CHK({k, d}, {3'b111, e})
  endtask
  initial begin
    nrst = 1'b0;
    supply = 1'b0;
    addrStrap = 2'b10;
    progOut = '0;
    num_errors = 0;
    n_compared = 0;
    repeat (20) @(posedge clock);
    #1 nrst = 1'b1;
    wr(DEV, 8'h00, 8'h00, 1, 3'b000);
    @(posedge clock);
    #1 supply = 1'b1;
    waitFor(0, 1'b1, 800);
    wr(DEV, 8'h00, 8'h00, 1, 3'b000);
    waitFor(0, 1'b0, 8000);
    for (int n = 0; n < 47; n++) `CHK(cfg(n), fac(n))
    wr(8'hA0, 8'h05, 8'h5A, 3, 3'b000);
    wr(8'hAA, 8'h05, 8'h5A, 3, 3'b111);
    `CHK(cfg(5), 8'h5A)
    rd(8'h05, 8'h5A);
    wr(DEV, 8'h2F, 8'h00, 2, 3'b100);
    wr(DEV, 8'hB0, 8'h00, 2, 3'b100);
    wr(DEV, 8'hC1, 8'h00, 2, 3'b110);
    // Block write cut after its count must not swallow the next data byte
    wr(DEV, 8'hC0, 8'h01, 3, 3'b111);
    wr(DEV, 8'h06, 8'h33, 3, 3'b111);
    `CHK(cfg(6), 8'h33)
    m.slowNs = 200.0;
    wr(DEV, 8'h45, 8'h3C, 3, 3'b111);
    m.slowNs = 0.0;
    wr(DEV, 8'h46, 8'h00, 2, 3'b100);
    `CHK(busy, 1'b1)
    waitFor(1, 1'b0, 3000);
    rd(8'h45, 8'h3C);
    for (int i = 0; i < 4; i++) begin
      wr(DEV, 8'h2C, wdl[i], 3, 3'b111);
      wr(DEV, 8'h2D, wdh[i], 3, 3'b111);
      @(posedge clock);
      #1 progOut = wdo[i];
      wr(DEV, 8'h45, 8'hC3, 3, {2'b11, !blk[i]});
      if (!blk[i]) waitFor(1, 1'b0, 3000);
      rd(8'h45, blk[i] ? 8'h3C : 8'hC3);
    end
    @(posedge clock);
    #1 progOut = '0;
    wr(DEV, 8'h2E, 8'h01, 3, 3'b111);
    wr(DEV, 8'h85, 8'h77, 3, 3'b110);
    `CHK(busy, 1'b0)
    wr(DEV, 8'h2E, 8'h00, 3, 3'b111);
    wr(DEV, 8'h85, 8'h77, 3, 3'b111);
    waitFor(1, 1'b0, 3000);
    `CHK(cfg(5), 8'h5A)
    wr(DEV, 8'hC4, 8'h00, 2, 3'b110);
    waitFor(0, 1'b1, 50);
    wr(DEV, 8'h05, 8'h00, 2, 3'b000);
    waitFor(0, 1'b0, 8000);
    `CHK(cfg(5), 8'h77)
    `CHK(cfg(44), 8'h00)
    `CHK(cfg(12), 8'h03)
    give_verdict();
  end
endmodule // cel_config_loader_tb
bind cel_config_loader cel_config_loader_asserts #(.EE_WRITE_TICKS(EE_WRITE_TICKS)) u_chk (
  .clock(clock), .nrst(nrst), .sclPin(sclPin), .sdaPin(sdaPin), .sdaOut_r(sdaOut_r),
  .sdaOeN_r(sdaOeN_r), .supplyAboveLockout(supplyAboveLockout), .addrStrap(addrStrap),
  .progOutActive(progOutActive), .loadActive_r(loadActive_r), .eeWriteBusy_r(eeWriteBusy_r),
  .cfgRegs(cfgRegs));
`default_nettype wire
